// *** design/pscc_pkg.sv ***
// constants and types shared by the power stage configuration block
package pscc_pkg;

	// ====================================================================
	// register map
	localparam logic [7:0] ADDR_PERIPH_ENABLE = 8'h00;
	localparam logic [7:0] ADDR_SYS_CONFIG = 8'h01;
	localparam logic [7:0] ADDR_STATUS = 8'h02;
	localparam logic [7:0] ADDR_PHASE_LOW = 8'h03;
	localparam logic [7:0] ADDR_PHASE_HIGH = 8'h04;

	// ====================================================================
	// analog_peripheral_enable fields
	localparam int PE_DIODE_EMU = 7;
	localparam int PE_TOPOLOGY = 6;
	localparam int PE_HS_DISABLE = 5;
	localparam int PE_LS_DISABLE = 4;
	localparam int PE_MEASURE = 3;
	localparam int PE_RAMP_SEL = 2;
	localparam int PE_UV_ACCEL = 1;
	localparam int PE_OV_ACCEL = 0;
	localparam logic [7:0] PE_RESET = 8'h30;

	// ====================================================================
	// system_configuration fields
	localparam int SC_CLAMP_SRC = 7;
	localparam int SC_PEDESTAL = 6;
	localparam int SC_REG_KEEP = 5;
	localparam int SC_CTRL_SEL = 4;
	localparam int SC_CLAMP_EN = 3;
	localparam int SC_FIELD_HI = 2;
	localparam logic [7:0] SC_RESET = 8'h40;

	// system_config_field codes
	localparam logic [2:0] CFG_STANDALONE = 3'h0;
	localparam logic [2:0] CFG_PHASE_MASTER = 3'h1;
	localparam logic [2:0] CFG_OUT_SLAVE_CLK = 3'h2;
	localparam logic [2:0] CFG_PHASE_SLAVE = 3'h4;
	localparam logic [2:0] CFG_OUT_MASTER = 3'h5;
	localparam logic [2:0] CFG_OUT_SLAVE_SYNC = 3'h6;

	// ====================================================================
	// status fields
	localparam int ST_UV_FLAG = 0;
	localparam int ST_UV_LEVEL = 1;
	localparam int ST_OV_LEVEL = 2;
	localparam int ST_CLOCK_PIN = 3;
	localparam int ST_DIODE_OFF = 4;
	localparam int ST_PHASE_BUSY = 5;

	typedef enum logic [1:0] {
		PSCC_RUN = 2'b01,
		PSCC_DIODE_OFF = 2'b10
	} pscc_gate_e;

endpackage : pscc_pkg

// *** design/pscc_top.sv ***
// power stage configuration registers and gate-drive control
// What this block does
// - diode emulation ends low-side pulse when low-side switch voltage reaches zero
// - after that cut both drives low until next period, then high-side on
// - bit 7 selects diode emulation when 1, synchronous rectification when 0
// - bit 5 set disables the high-side driver; resets to 1
// - bit 4 set disables the low-side driver; resets to 1
// - undervoltage accelerator holds high side on, low side off while below threshold
// - overvoltage accelerator holds both switches off while above threshold
// - with measurement idle, bit 2 routes ramp valley (0) or peak (1)
// - writing 1 to bit 3 starts measurement; 0 means none in progress
// - bit 6 selects boost when 1, buck when 0; resets to 0
// - clamp enable bit turns amplifier clamp on; cleared by reset
// - clamp source set uses pin voltage alone, clear adds sampled current
// - pedestal enable is set on every reset; software may clear it
// - in sleep the regulator stays up only if the keep bit is set
// - control select clear regulates voltage, set regulates load current
// - as master drive sync pin with period sync, clock pin with osc8_in
// - code 010 makes sync and clock pins inputs fed by the master
// - code 110 makes both pins inputs; only the sync pin is used, no clock
// - slave applies programmable phase shift from low and high phase registers
// - a disabled driver holds its output low
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pscc_top (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic mod_high_in,
	input wire logic mod_low_in,
	input wire logic period_start_in,
	input wire logic measure_done_in,
	input wire logic sleep_in,
	input wire logic osc8_in,
	input wire logic zero_cross_in,
	input wire logic uv_cmp_in,
	input wire logic ov_cmp_in,
	input wire logic sync_pin_in,
	output logic sync_pin_out,
	output logic sync_pin_oe_out,
	input wire logic clock_pin_in,
	output logic clock_pin_out,
	output logic clock_pin_oe_out,
	output logic high_side_drive_out,
	output logic low_side_drive_out,
	output logic topology_boost_out,
	output logic ramp_peak_select_out,
	output logic measure_active_out,
	output logic clamp_enable_out,
	output logic clamp_source_pin_out,
	output logic pedestal_enable_out,
	output logic regulator_low_power_out,
	output logic current_regulation_out,
	output logic undervoltage_event_flag_out
);

	// ====================================================================
	// state
	typedef struct packed {
		logic [7:0] pe;
		logic [7:0] sc;
		logic [7:0] phl;
		logic [7:0] phh;
		logic [7:0] rdata;
		logic uv_flag;
		logic [1:0] zc_s;
		logic [1:0] uv_s;
		logic [1:0] ov_s;
		logic [1:0] syn_s;
		logic [1:0] clk_s;
		logic syn_prev;
		logic [15:0] ph_cnt;
		logic ph_busy;
		pscc_pkg::pscc_gate_e gate;
		logic hs;
		logic ls;
		logic sync_out;
		logic clk_out;
		logic reg_low;
	} pscc_state_s;

	localparam pscc_state_s STATE_RESET = '{
		pe: pscc_pkg::PE_RESET,
		sc: pscc_pkg::SC_RESET,
		gate: pscc_pkg::PSCC_RUN,
		default: '0
	};

	pscc_state_s state_q;
	pscc_state_s state_d;

	// ====================================================================
	// pin direction decode
	function automatic logic [1:0] pscc_pin_drive(input logic [2:0] field);
		// bit 1 drives sync pin, bit 0 drives clock pin
		case (field)
			pscc_pkg::CFG_PHASE_MASTER,
			pscc_pkg::CFG_OUT_MASTER: pscc_pin_drive = 2'h3;
			default: pscc_pin_drive = 2'h0;
		endcase
	endfunction : pscc_pin_drive

	function automatic logic pscc_is_slave(input logic [2:0] field);
		case (field)
			pscc_pkg::CFG_OUT_SLAVE_CLK,
			pscc_pkg::CFG_PHASE_SLAVE,
			pscc_pkg::CFG_OUT_SLAVE_SYNC: pscc_is_slave = 1'b1;
			default: pscc_is_slave = 1'b0;
		endcase
	endfunction : pscc_is_slave

	logic [2:0] cfg_field;
	logic slave_mode;
	logic sync_rise;
	logic slave_start;
	logic period_go;
	logic zc_seen;
	logic uv_act;
	logic ov_act;
	logic hs_dis;
	logic ls_dis;
	logic flag_clear;
	logic [1:0] pin_drive;

	assign cfg_field = state_q.sc[pscc_pkg::SC_FIELD_HI:0];
	assign slave_mode = pscc_is_slave(cfg_field);
	assign sync_rise = state_q.syn_s[1] & ~state_q.syn_prev;
	assign slave_start = state_q.ph_busy & (state_q.ph_cnt == 16'h0000);
	assign period_go = slave_mode ? slave_start : period_start_in;
	assign zc_seen = state_q.zc_s[1];
	assign uv_act = state_q.pe[pscc_pkg::PE_UV_ACCEL] & state_q.uv_s[1];
	assign ov_act = state_q.pe[pscc_pkg::PE_OV_ACCEL] & state_q.ov_s[1];
	assign hs_dis = state_q.pe[pscc_pkg::PE_HS_DISABLE];
	assign ls_dis = state_q.pe[pscc_pkg::PE_LS_DISABLE];
	assign flag_clear = reg_wr_in & (reg_addr_in == pscc_pkg::ADDR_STATUS)
		& reg_wdata_in[pscc_pkg::ST_UV_FLAG];
	assign pin_drive = pscc_pin_drive(cfg_field);

	// ====================================================================
	// next state
	always_comb
	begin
		logic hs_cmd;
		logic ls_cmd;
		logic [7:0] status;
		hs_cmd = mod_high_in;
		ls_cmd = mod_low_in;
		status = 8'h00;
		state_d = state_q;

		// pins pass two flops; only stage 1 reads stage 0
		state_d.zc_s = {state_q.zc_s[0], zero_cross_in};
		state_d.uv_s = {state_q.uv_s[0], uv_cmp_in};
		state_d.ov_s = {state_q.ov_s[0], ov_cmp_in};
		state_d.syn_s = {state_q.syn_s[0], sync_pin_in};
		state_d.clk_s = {state_q.clk_s[0], clock_pin_in};
		state_d.syn_prev = state_q.syn_s[1];

		// register writes
		if (reg_wr_in)
		begin
			case (reg_addr_in)
				pscc_pkg::ADDR_PERIPH_ENABLE: state_d.pe = reg_wdata_in;
				pscc_pkg::ADDR_SYS_CONFIG: state_d.sc = reg_wdata_in;
				pscc_pkg::ADDR_PHASE_LOW: state_d.phl = reg_wdata_in;
				pscc_pkg::ADDR_PHASE_HIGH: state_d.phh = reg_wdata_in;
				default: ;
			endcase
		end

		// measurement start and finish
		// a write of 0 cannot abort; a start in the done cycle survives
		state_d.pe[pscc_pkg::PE_MEASURE] =
			(state_q.pe[pscc_pkg::PE_MEASURE] & ~measure_done_in)
			| (reg_wr_in & (reg_addr_in == pscc_pkg::ADDR_PERIPH_ENABLE)
			& reg_wdata_in[pscc_pkg::PE_MEASURE]);

		// sticky flag, set wins over clear
		state_d.uv_flag = (state_q.uv_flag & ~flag_clear) | state_q.uv_s[1];

		// phase shift counted from the received sync edge
		if (slave_mode && sync_rise)
		begin
			state_d.ph_cnt = {state_q.phh, state_q.phl};
			state_d.ph_busy = 1'b1;
		end
		else if (slave_start)
		begin
			state_d.ph_busy = 1'b0;
		end
		else if (state_q.ph_busy)
		begin
			state_d.ph_cnt = state_q.ph_cnt - 16'h0001;
		end

		// diode emulation cut of low-side pulse
		case (state_q.gate)
			pscc_pkg::PSCC_RUN:
			begin
				if (state_q.pe[pscc_pkg::PE_DIODE_EMU] && state_q.ls && zc_seen
					&& !period_go)
				begin
					state_d.gate = pscc_pkg::PSCC_DIODE_OFF;
					ls_cmd = 1'b0;
				end
			end
			pscc_pkg::PSCC_DIODE_OFF:
			begin
				// both low until the next period, then high side on
				hs_cmd = period_go;
				ls_cmd = 1'b0;
				if (period_go)
				begin
					state_d.gate = pscc_pkg::PSCC_RUN;
				end
			end
			default: state_d.gate = pscc_pkg::PSCC_RUN;
		endcase

		if (uv_act)
		begin
			hs_cmd = 1'b1;
			ls_cmd = 1'b0;
		end
		if (ov_act)
		begin
			hs_cmd = 1'b0;
			ls_cmd = 1'b0;
		end
		state_d.hs = hs_cmd & ~hs_dis;
		state_d.ls = ls_cmd & ~ls_dis;

		state_d.sync_out = period_start_in;
		state_d.clk_out = osc8_in;

		// regulator drops only in sleep with keep bit clear
		state_d.reg_low = sleep_in & ~state_q.sc[pscc_pkg::SC_REG_KEEP];

		// register reads, data valid only in the cycle after the strobe
		status[pscc_pkg::ST_UV_FLAG] = state_q.uv_flag;
		status[pscc_pkg::ST_UV_LEVEL] = state_q.uv_s[1];
		status[pscc_pkg::ST_OV_LEVEL] = state_q.ov_s[1];
		status[pscc_pkg::ST_CLOCK_PIN] = state_q.clk_s[1];
		status[pscc_pkg::ST_DIODE_OFF] = (state_q.gate == pscc_pkg::PSCC_DIODE_OFF);
		status[pscc_pkg::ST_PHASE_BUSY] = state_q.ph_busy;
		state_d.rdata = 8'h00;
		if (reg_rd_in)
		begin
			case (reg_addr_in)
				pscc_pkg::ADDR_PERIPH_ENABLE: state_d.rdata = state_q.pe;
				pscc_pkg::ADDR_SYS_CONFIG: state_d.rdata = state_q.sc;
				pscc_pkg::ADDR_STATUS: state_d.rdata = status;
				pscc_pkg::ADDR_PHASE_LOW: state_d.rdata = state_q.phl;
				pscc_pkg::ADDR_PHASE_HIGH: state_d.rdata = state_q.phh;
				default: state_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_q <= STATE_RESET;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// ====================================================================
	// outputs
	assign reg_rdata_out = state_q.rdata;
	assign high_side_drive_out = state_q.hs;
	assign low_side_drive_out = state_q.ls;
	// slave codes leave both pins undriven
	assign sync_pin_oe_out = pin_drive[1];
	assign clock_pin_oe_out = pin_drive[0];
	assign sync_pin_out = state_q.sync_out;
	assign clock_pin_out = state_q.clk_out;
	assign topology_boost_out = state_q.pe[pscc_pkg::PE_TOPOLOGY];
	// ramp point only meaningful while measurement idle
	assign ramp_peak_select_out = state_q.pe[pscc_pkg::PE_RAMP_SEL];
	assign measure_active_out = state_q.pe[pscc_pkg::PE_MEASURE];
	assign clamp_enable_out = state_q.sc[pscc_pkg::SC_CLAMP_EN];
	assign clamp_source_pin_out = state_q.sc[pscc_pkg::SC_CLAMP_SRC];
	assign pedestal_enable_out = state_q.sc[pscc_pkg::SC_PEDESTAL];
	assign regulator_low_power_out = state_q.reg_low;
	assign current_regulation_out = state_q.sc[pscc_pkg::SC_CTRL_SEL];
	assign undervoltage_event_flag_out = state_q.uv_flag;

	// ====================================================================
	// checks
	default clocking pscc_cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	sequence s_diode_cut;
		state_q.gate == pscc_pkg::PSCC_RUN && state_q.pe[pscc_pkg::PE_DIODE_EMU]
			&& state_q.ls && zc_seen && !period_go;
	endsequence

	sequence s_diode_restart;
		state_q.gate == pscc_pkg::PSCC_DIODE_OFF && period_go
			&& !hs_dis && !uv_act && !ov_act;
	endsequence

	a_hs_disable_low: assert property (hs_dis |=> !high_side_drive_out)
		else $error("high side driven while disabled");
	a_ls_disable_low: assert property (ls_dis |=> !low_side_drive_out)
		else $error("low side driven while disabled");
	a_ov_both_off: assert property (ov_act
		|=> !high_side_drive_out && !low_side_drive_out)
		else $error("overvoltage accelerator left a switch on");
	a_uv_high_on: assert property (uv_act && !ov_act && !hs_dis
		|=> high_side_drive_out && !low_side_drive_out)
		else $error("undervoltage accelerator did not hold high side");
	a_diode_cut_hold: assert property (s_diode_cut
		|=> state_q.gate == pscc_pkg::PSCC_DIODE_OFF && !low_side_drive_out)
		else $error("diode emulation did not end low-side pulse");
	a_diode_next_period: assert property (s_diode_restart
		|=> high_side_drive_out && state_q.gate == pscc_pkg::PSCC_RUN)
		else $error("high side not asserted at next period");
	a_uv_flag_sticky: assert property (undervoltage_event_flag_out && !flag_clear
		|=> undervoltage_event_flag_out)
		else $error("undervoltage flag lost without clear");
	a_measure_hold: assert property (measure_active_out && !measure_done_in
		|=> measure_active_out)
		else $error("measurement ended without done");
	a_read_config: assert property (reg_rd_in
		&& reg_addr_in == pscc_pkg::ADDR_SYS_CONFIG
		|=> reg_rdata_out == $past(state_q.sc))
		else $error("configuration read returned wrong data");
	a_slave_pins_in: assert property (slave_mode
		|-> !sync_pin_oe_out && !clock_pin_oe_out)
		else $error("slave drives a sync or clock pin");

endmodule : pscc_top

`default_nettype wire

// *** tb/pscc_peer_model.sv ***
// far-side controller model acting as the master of the sync and clock lines
`timescale 1ns/1ps
`default_nettype none

module pscc_peer_model #(
	parameter int SYNC_PERIOD = 16
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	output logic sync_out,
	output logic clock_out
);
	int cnt_q;

	// ====================================================================
	// master line generation
	// master supplies sync and clock
	// sync pulse also serves sync-only slaves
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			cnt_q <= 0;
			sync_out <= 1'b0;
			clock_out <= 1'b0;
		end
		else
		begin
			cnt_q <= (cnt_q == SYNC_PERIOD - 1) ? 0 : cnt_q + 1;
			sync_out <= (cnt_q == 0);
			clock_out <= ~clock_out;
		end
	end
endmodule : pscc_peer_model

`default_nettype wire

// *** tb/test_power_stage_config_control.sv ***
// self-checking testbench for the power stage configuration block
`timescale 1ns/1ps
`default_nettype none

module test_power_stage_config_control;
	logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdata, v;
	logic mh = 0, ml = 0, ps = 0, md = 0, slp = 0, osc = 0, zc = 0, uv = 0, ov = 0;
	logic sync_o, sync_oe, ck_o, ck_oe, hs, ls, topology_select, ramp, meas;
	logic clen, clsrc, ped, lowp, curr, uvf, p_sync, p_clk;
	wire logic sync_w = sync_oe ? sync_o : p_sync;
	wire logic ck_w = ck_oe ? ck_o : p_clk;
	int errors = 0, n_checks = 0;

	pscc_top uut (.sys_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr),
		.reg_wdata_in(wd), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
		.mod_high_in(mh), .mod_low_in(ml), .period_start_in(ps), .measure_done_in(md),
		.sleep_in(slp), .osc8_in(osc), .zero_cross_in(zc), .uv_cmp_in(uv), .ov_cmp_in(ov),
		.sync_pin_in(sync_w), .sync_pin_out(sync_o), .sync_pin_oe_out(sync_oe),
		.clock_pin_in(ck_w), .clock_pin_out(ck_o), .clock_pin_oe_out(ck_oe),
		.high_side_drive_out(hs), .low_side_drive_out(ls), .topology_boost_out(topology_select),
		.ramp_peak_select_out(ramp), .measure_active_out(meas), .clamp_enable_out(clen),
		.clamp_source_pin_out(clsrc), .pedestal_enable_out(ped),
		.regulator_low_power_out(lowp), .current_regulation_out(curr),
		.undervoltage_event_flag_out(uvf));

	pscc_peer_model peer (.clk_in(clk), .reset_n_in(rst_n), .sync_out(p_sync),
		.clock_out(p_clk));

	// ====================================================================
	// clock, reset and helpers
	initial
	begin
		forever #5 clk = ~clk;
	end

	always @(posedge clk) osc <= ~osc;

	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask : rd

	task automatic gates(input string n, input logic h, input logic l);
		chk({n, " hs"}, {7'h00, hs}, {7'h00, h});
		chk({n, " ls"}, {7'h00, ls}, {7'h00, l});
	endtask : gates

	// ====================================================================
	// scenarios
	task automatic t_reset();
		rd(pscc_pkg::ADDR_PERIPH_ENABLE, v);
		chk("pe reset", v, 8'h30);
		rd(pscc_pkg::ADDR_SYS_CONFIG, v);
		chk("sc reset", v, 8'h40);
		@(posedge clk);
		mh <= 1'b1;
		ml <= 1'b1;
		cyc(3);
		gates("disabled", 1'b0, 1'b0);
		chk("pedestal", {7'h00, ped}, 8'h01);
	endtask : t_reset

	task automatic t_enable();
		wr(pscc_pkg::ADDR_PERIPH_ENABLE, 8'h00);
		cyc(3);
		gates("enabled", 1'b1, 1'b1);
		wr(8'h10, 8'hFF);
		rd(8'h10, v);
		chk("unmapped", v, 8'h00);
		wr(pscc_pkg::ADDR_PERIPH_ENABLE, 8'h10);
		cyc(3);
		gates("ls off", 1'b1, 1'b0);
	endtask : t_enable

	task automatic t_diode();
		wr(pscc_pkg::ADDR_PERIPH_ENABLE, 8'h80);
		@(posedge clk);
		mh <= 1'b0;
		ml <= 1'b1;
		cyc(3);
		gates("diode run", 1'b0, 1'b1);
		@(posedge clk);
		zc <= 1'b1;
		cyc(4);
		gates("diode cut", 1'b0, 1'b0);
		@(posedge clk);
		zc <= 1'b0;
		mh <= 1'b1;
		ml <= 1'b0;
		cyc(4);
		gates("diode hold", 1'b0, 1'b0);
		@(posedge clk);
		ps <= 1'b1;
		@(posedge clk);
		ps <= 1'b0;
		cyc(1);
		gates("next period", 1'b1, 1'b0);
	endtask : t_diode

	task automatic t_accel();
		wr(pscc_pkg::ADDR_PERIPH_ENABLE, 8'h02);
		@(posedge clk);
		mh <= 1'b0;
		ml <= 1'b1;
		uv <= 1'b1;
		cyc(4);
		gates("uv", 1'b1, 1'b0);
		@(posedge clk);
		ov <= 1'b1;
		wr(pscc_pkg::ADDR_PERIPH_ENABLE, 8'h03);
		cyc(4);
		gates("ov", 1'b0, 1'b0);
		@(posedge clk);
		ov <= 1'b0;
		wr(pscc_pkg::ADDR_PERIPH_ENABLE, 8'h22);
		cyc(4);
		gates("uv disabled", 1'b0, 1'b0);
		@(posedge clk);
		uv <= 1'b0;
		wr(pscc_pkg::ADDR_PERIPH_ENABLE, 8'h02);
		cyc(4);
		gates("uv over", 1'b0, 1'b1);
		chk("uv flag", {7'h00, uvf}, 8'h01);
		wr(pscc_pkg::ADDR_STATUS, 8'h01);
		cyc(1);
		chk("uv flag clr", {7'h00, uvf}, 8'h00);
	endtask : t_accel

	task automatic t_cfg();
		wr(pscc_pkg::ADDR_PERIPH_ENABLE, 8'h4C);
		wr(pscc_pkg::ADDR_SYS_CONFIG, 8'hB8);
		@(posedge clk);
		slp <= 1'b1;
		cyc(2);
		chk("pe outs", {5'h00, topology_select, ramp, meas}, 8'h07);
		chk("sc outs", {4'h0, clsrc, ped, curr, clen}, 8'h0B);
		chk("keep reg", {7'h00, lowp}, 8'h00);
		wr(pscc_pkg::ADDR_SYS_CONFIG, 8'h40);
		wr(pscc_pkg::ADDR_PERIPH_ENABLE, 8'h00);
		cyc(2);
		chk("low power", {7'h00, lowp}, 8'h01);
		chk("sc clear", {4'h0, clsrc, ped, curr, clen}, 8'h04);
		chk("measuring", {7'h00, meas}, 8'h01);
		chk("pe clear", {6'h00, topology_select, ramp}, 8'h00);
		@(posedge clk);
		md <= 1'b1;
		slp <= 1'b0;
		@(posedge clk);
		md <= 1'b0;
		cyc(2);
		chk("measure done", {7'h00, meas}, 8'h00);
		wr(pscc_pkg::ADDR_PERIPH_ENABLE, 8'h04);
		cyc(2);
		chk("ramp idle", {5'h00, topology_select, ramp, meas}, 8'h02);
	endtask : t_cfg

	task automatic t_codes();
		for (int c = 0; c < 7; c++)
		begin
			wr(pscc_pkg::ADDR_SYS_CONFIG, 8'h40 | 8'(c));
			cyc(2);
			chk("oe", {6'h00, sync_oe, ck_oe}, (c == 1 || c == 5) ? 8'h03 : 8'h00);
		end
		wr(pscc_pkg::ADDR_SYS_CONFIG, 8'h45);
		@(posedge clk);
		ps <= 1'b1;
		@(posedge clk);
		ps <= 1'b0;
		@(negedge clk);
		chk("sync out", {7'h00, sync_o}, 8'h01);
		chk("clock out", {7'h00, ck_o}, {7'h00, ~osc});
	endtask : t_codes

	// busy spans the shift plus one cycle after the synced edge
	task automatic t_slave();
		wr(pscc_pkg::ADDR_PHASE_LOW, 8'h03);
		wr(pscc_pkg::ADDR_SYS_CONFIG, 8'h42);
		cyc(8);
		@(posedge p_sync);
		repeat (2) @(posedge clk);
		rd(pscc_pkg::ADDR_STATUS, v);
		chk("phase busy", {7'h00, v[pscc_pkg::ST_PHASE_BUSY]}, 8'h01);
		rd(pscc_pkg::ADDR_STATUS, v);
		chk("phase hold", {7'h00, v[pscc_pkg::ST_PHASE_BUSY]}, 8'h01);
		rd(pscc_pkg::ADDR_STATUS, v);
		chk("phase end", {7'h00, v[pscc_pkg::ST_PHASE_BUSY]}, 8'h00);
	endtask : t_slave

	task automatic t_rereset();
		wr(pscc_pkg::ADDR_SYS_CONFIG, 8'h08);
		wr(pscc_pkg::ADDR_PERIPH_ENABLE, 8'h00);
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		rd(pscc_pkg::ADDR_SYS_CONFIG, v);
		chk("sc rereset", v, 8'h40);
		rd(pscc_pkg::ADDR_PERIPH_ENABLE, v);
		chk("pe rereset", v, 8'h30);
		gates("rereset", 1'b0, 1'b0);
	endtask : t_rereset

	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_enable();
		t_diode();
		t_accel();
		t_cfg();
		t_codes();
		t_slave();
		t_rereset();
		stop_test();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		stop_test();
	end
endmodule : test_power_stage_config_control

`default_nettype wire
